// [design/crtc_vsplit_pkg.sv]
// Purpose: Shared constants and helpers for the vertical blank, mode
//          control and split-screen block.
// Assumes: Eight-bit indexed CRT controller register port.
// Notes:   Mode field positions refer to the mode control register; extension bits to neighbouring ones.
package crtc_vsplit_pkg;

  // ************************************************************
  // Register indexes
  // ************************************************************
  localparam logic [7:0] IDX_VBLANK_START = 8'h15;
  localparam logic [7:0] IDX_VBLANK_END   = 8'h16;
  localparam logic [7:0] IDX_MODE_CTL     = 8'h17;
  localparam logic [7:0] IDX_SPLIT_LINE   = 8'h18;
  localparam logic [7:0] IDX_CPU_LATCH    = 8'h22;
  localparam logic [7:0] IDX_ATTR_A       = 8'h24;
  localparam logic [7:0] IDX_ATTR_B       = 8'h26;

  // ************************************************************
  // Mode control fields and reset
  // ************************************************************
  localparam int MD_BANK13  = 0;
  localparam int MD_BANK14  = 1;
  localparam int MD_VHALVE  = 2;
  localparam int MD_WHALVE  = 3;
  localparam int MD_WRAP    = 5;
  localparam int MD_BYTE    = 6;
  localparam int MD_RETRACE = 7;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] MODE_MASK  = 8'hef;

  // ************************************************************
  // Extension bit positions in neighbouring registers
  // ************************************************************
  localparam int VOV_VBS8 = 3;
  localparam int MSL_VBS9 = 5;
  localparam int XOV_VBS10 = 2;
  localparam int VOV_LC8  = 4;
  localparam int MSL_LC9  = 6;
  localparam int XOV_LC10 = 6;
  localparam int MSL_ROW_HI = 4;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [10:0] join11(input logic [7:0] lo,
                                         input logic b8,
                                         input logic b9,
                                         input logic b10);
    join11 = {b10, b9, b8, lo};
  endfunction : join11

  // Row pitch in bytes: offset times 2, 4 or 8
  function automatic logic [15:0] row_step(input logic [7:0] off,
                                           input logic dword,
                                           input logic qword);
    if (qword) begin
      row_step = {5'h00, off, 3'h0};
    end else if (dword) begin
      row_step = {6'h00, off, 2'h0};
    end else begin
      row_step = {7'h00, off, 1'h0};
    end
  endfunction : row_step

endpackage : crtc_vsplit_pkg

// [design/vblank_gen.sv]
// Purpose: Vertical blank flag from start and end line matches.
// Assumes: Scan line input is registered and steady between lines.
// Notes:   A start match outranks an end match on the same line.
`timescale 1ns/10ps
module vblank_gen (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [10:0] scan_line,
  input  wire logic [10:0] start_line,
  input  wire logic [7:0]  end_line,
  output logic             vblank
);

  typedef struct packed {
    logic blank;
  } vb_state_t;

  vb_state_t s_r;
  vb_state_t s_nxt;
  logic [10:0] first_line;

  assign first_line = 11'(start_line + 11'h001);

  always_comb begin
    s_nxt = s_r;
    if (scan_line == first_line) begin
      s_nxt.blank = 1'b1;
    end else if (scan_line[7:0] == end_line) begin
      s_nxt.blank = 1'b0;
    end
  end

  // Holds through the frame wrap until the end match
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign vblank = s_r.blank;

  property p_blank_start;
    @(posedge sys_clk) disable iff (srst)
    scan_line == first_line |=> vblank;
  endproperty
  a_blank_start: assert property (p_blank_start)
    else $error("blank not raised at start line");

  property p_blank_end;
    @(posedge sys_clk) disable iff (srst)
    scan_line != first_line && scan_line[7:0] == end_line |=> !vblank;
  endproperty
  a_blank_end: assert property (p_blank_end)
    else $error("blank not dropped at end line");

  property p_blank_hold;
    @(posedge sys_clk) disable iff (srst)
    vblank && scan_line[7:0] != end_line |=> vblank;
  endproperty
  a_blank_hold: assert property (p_blank_hold)
    else $error("blank dropped before end line");

  c_blank_rise: cover property (@(posedge sys_clk) $rose(vblank));

endmodule : vblank_gen

// [design/addr_mux.sv]
// Purpose: Maps the memory address counter onto the address output.
// Assumes: Row scan counter and display-active flag are registered.
// Notes:   Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module addr_mux (
  input  wire logic [15:0] count,
  input  wire logic [1:0]  row_scan,
  input  wire logic        disp_active,
  input  wire logic [7:0]  mode,
  output logic [15:0]      addr
);

  logic [15:0] shifted;

  always_comb begin
    if (mode[crtc_vsplit_pkg::MD_BYTE]) begin
      shifted = count;
    end else begin
      // Word mode: shift up, wrap bit fills the freed low bit
      shifted = {count[14:0], mode[crtc_vsplit_pkg::MD_WRAP] ?
                 count[15] : count[13]};
    end
    addr = shifted;
    if (disp_active && !mode[crtc_vsplit_pkg::MD_BANK13]) begin
      addr[13] = row_scan[0];
    end
    if (disp_active && !mode[crtc_vsplit_pkg::MD_BANK14]) begin
      addr[14] = row_scan[1];
    end
  end

endmodule : addr_mux

// [design/crtc_vblank_split_mode_ctl.sv]
// Purpose: Vertical blank, mode control, split screen and two
//          readback registers of a CRT controller.
// Assumes: Ticks for line retrace and character clock are one-cycle
//          pulses synchronous to sys_clk.
// Notes:   Register reads return data one cycle after the strobe.
`timescale 1ns/10ps

// Behaviour
// - Blank starts at programmed start plus one
// - Start value joins three overflow extension bits
// - Blank ends when low line byte matches
// - Mode bit0 clear puts row bit0 on A13 while disp_active is high
// - Mode bit1 clear puts row bit1 on A14 while disp_active is high
// - Mode bit2 halves the vertical line clock
// - Mode bit3 advances address every second character
// - Mode bit5 picks counter bit for A0
// - Mode bit6 clear selects shifted word addressing
// - Mode bit7 clear silences both retrace pulses
// - Mode register resets zero, bit4 reads zero
// - Split line match clears address counter
// - Split value joins three overflow extension bits
// - Latch readback picks plane by select bits
// - Attribute readback answers at two indexes
// - Attribute readback packs index, enable, toggle
// - Row pitch is offset times two, four, eight
module crtc_vblank_split_mode_ctl (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic [7:0]  reg_index,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic [7:0]  vertical_overflow_reg,
  input  wire logic [7:0]  max_scan_line_reg,
  input  wire logic [7:0]  extended_vertical_overflow_reg,
  input  wire logic [7:0]  row_offset_reg,
  input  wire logic [1:0]  read_plane_select_reg,
  input  wire logic [10:0] vertical_total,
  input  wire logic [15:0] start_address,
  input  wire logic        dword_mode,
  input  wire logic        qword_mode,
  input  wire logic [31:0] cpu_latch_planes,
  input  wire logic [4:0]  attr_index,
  input  wire logic        video_display_enable_flag,
  input  wire logic        attr_address_toggle,
  input  wire logic        hretrace_tick,
  input  wire logic        char_tick,
  input  wire logic        disp_active,
  input  wire logic        hsync_raw,
  input  wire logic        vsync_raw,
  output logic             hsync_out,
  output logic             vsync_out,
  output logic             vblank,
  output logic [15:0]      mem_addr,
  output logic [10:0]      scan_line,
  output logic [4:0]       row_scan
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]  vbs;
    logic [7:0]  vbe;
    logic [7:0]  mode;
    logic [7:0]  split;
    logic [7:0]  rdata;
    logic [10:0] line;
    logic [4:0]  row;
    logic        vdiv;
    logic        cdiv;
    logic [15:0] ma;
    logic [15:0] base;
    logic [15:0] addr;
    logic        hs;
    logic        vs;
  } ctl_state_t;

  ctl_state_t  s_r;
  ctl_state_t  s_nxt;
  logic [10:0] vbs11;
  logic [10:0] split11;
  logic [15:0] mux_addr;
  logic [7:0]  latch_sel;
  logic [7:0]  attr_rb;
  logic        line_adv;

  // ************************************************************
  // Assembled compare values
  // ************************************************************
  assign vbs11 = crtc_vsplit_pkg::join11(s_r.vbs,
    vertical_overflow_reg[crtc_vsplit_pkg::VOV_VBS8],
    max_scan_line_reg[crtc_vsplit_pkg::MSL_VBS9],
    extended_vertical_overflow_reg[crtc_vsplit_pkg::XOV_VBS10]);
  assign split11 = crtc_vsplit_pkg::join11(s_r.split,
    vertical_overflow_reg[crtc_vsplit_pkg::VOV_LC8],
    max_scan_line_reg[crtc_vsplit_pkg::MSL_LC9],
    extended_vertical_overflow_reg[crtc_vsplit_pkg::XOV_LC10]);

  assign latch_sel = cpu_latch_planes[{read_plane_select_reg, 3'h0} +: 8];
  assign attr_rb = {~attr_address_toggle, 1'b0,
                    video_display_enable_flag, attr_index};

  // Halved vertical clock skips every other retrace tick
  assign line_adv = hretrace_tick &&
    (!s_r.mode[crtc_vsplit_pkg::MD_VHALVE] || s_r.vdiv);

  addr_mux u_addr_mux (
    .count       (s_r.ma),
    .row_scan    (s_r.row[1:0]),
    .disp_active (disp_active),
    .mode        (s_r.mode),
    .addr        (mux_addr)
  );

  vblank_gen u_vblank_gen (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .scan_line  (s_r.line),
    .start_line (vbs11),
    .end_line   (s_r.vbe),
    .vblank     (vblank)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [10:0] nline;
    logic [15:0] nbase;
    nline = '0;
    nbase = '0;
    s_nxt = s_r;
    // Readback indexes have no write target
    if (reg_wr) begin
      if (reg_index == crtc_vsplit_pkg::IDX_VBLANK_START) begin
        s_nxt.vbs = reg_wdata;
      end else if (reg_index == crtc_vsplit_pkg::IDX_VBLANK_END) begin
        s_nxt.vbe = reg_wdata;
      end else if (reg_index == crtc_vsplit_pkg::IDX_MODE_CTL) begin
        s_nxt.mode = reg_wdata & crtc_vsplit_pkg::MODE_MASK;
      end else if (reg_index == crtc_vsplit_pkg::IDX_SPLIT_LINE) begin
        s_nxt.split = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_index == crtc_vsplit_pkg::IDX_VBLANK_START) begin
        s_nxt.rdata = s_r.vbs;
      end else if (reg_index == crtc_vsplit_pkg::IDX_VBLANK_END) begin
        s_nxt.rdata = s_r.vbe;
      end else if (reg_index == crtc_vsplit_pkg::IDX_MODE_CTL) begin
        s_nxt.rdata = s_r.mode;
      end else if (reg_index == crtc_vsplit_pkg::IDX_SPLIT_LINE) begin
        s_nxt.rdata = s_r.split;
      end else if (reg_index == crtc_vsplit_pkg::IDX_CPU_LATCH) begin
        s_nxt.rdata = latch_sel;
      end else if (reg_index == crtc_vsplit_pkg::IDX_ATTR_A ||
                   reg_index == crtc_vsplit_pkg::IDX_ATTR_B) begin
        s_nxt.rdata = attr_rb;
      end else begin
        s_nxt.rdata = 8'h00;
      end
    end

    if (hretrace_tick) begin
      s_nxt.vdiv = ~s_r.vdiv;
    end
    if (line_adv) begin
      s_nxt.cdiv = 1'b0;
      if (s_r.line == vertical_total) begin
        nline = 11'h000;
        s_nxt.row = 5'h00;
        nbase = start_address;
      end else begin
        nline = 11'(s_r.line + 11'h001);
        if (s_r.row == max_scan_line_reg[crtc_vsplit_pkg::MSL_ROW_HI:0])
        begin
          s_nxt.row = 5'h00;
          nbase = 16'(s_r.base + crtc_vsplit_pkg::row_step(
            row_offset_reg, dword_mode, qword_mode));
        end else begin
          s_nxt.row = 5'(s_r.row + 5'h01);
          nbase = s_r.base;
        end
      end
      // Split screen restarts display memory at zero
      if (nline == split11) begin
        nbase = 16'h0000;
      end
      s_nxt.line = nline;
      s_nxt.base = nbase;
      s_nxt.ma = nbase;
    end else if (char_tick && disp_active) begin
      s_nxt.cdiv = ~s_r.cdiv;
      if (!s_r.mode[crtc_vsplit_pkg::MD_WHALVE] || s_r.cdiv) begin
        s_nxt.ma = 16'(s_r.ma + 16'h0001);
      end
    end

    s_nxt.addr = mux_addr;
    s_nxt.hs = hsync_raw && s_r.mode[crtc_vsplit_pkg::MD_RETRACE];
    s_nxt.vs = vsync_raw && s_r.mode[crtc_vsplit_pkg::MD_RETRACE];
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.mode <= crtc_vsplit_pkg::MODE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_rdata = s_r.rdata;
  assign hsync_out = s_r.hs;
  assign vsync_out = s_r.vs;
  assign mem_addr  = s_r.addr;
  assign scan_line = s_r.line;
  assign row_scan  = s_r.row;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_mode_reset;
    @(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> s_r.mode == crtc_vsplit_pkg::MODE_RESET;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("mode control not zero after reset");

  property p_mode_bit4;
    @(posedge sys_clk) disable iff (srst)
    reg_rd && reg_index == crtc_vsplit_pkg::IDX_MODE_CTL
      |=> reg_rdata[4] == 1'b0;
  endproperty
  a_mode_bit4: assert property (p_mode_bit4)
    else $error("reserved mode bit read as one");

  property p_retrace_off;
    @(posedge sys_clk) disable iff (srst)
    !s_r.mode[crtc_vsplit_pkg::MD_RETRACE] |=> !hsync_out && !vsync_out;
  endproperty
  a_retrace_off: assert property (p_retrace_off)
    else $error("retrace pulse while disabled");

  property p_bank13;
    @(posedge sys_clk) disable iff (srst)
    disp_active && !s_r.mode[crtc_vsplit_pkg::MD_BANK13]
      |=> mem_addr[13] == $past(s_r.row[0]);
  endproperty
  a_bank13: assert property (p_bank13)
    else $error("row bit0 not on address bit 13");

  property p_bank14;
    @(posedge sys_clk) disable iff (srst)
    disp_active && !s_r.mode[crtc_vsplit_pkg::MD_BANK14]
      |=> mem_addr[14] == $past(s_r.row[1]);
  endproperty
  a_bank14: assert property (p_bank14)
    else $error("row bit1 not on address bit 14");

  property p_wrap15;
    @(posedge sys_clk) disable iff (srst)
    !s_r.mode[crtc_vsplit_pkg::MD_BYTE] && s_r.mode[crtc_vsplit_pkg::MD_WRAP]
      |=> mem_addr[0] == $past(s_r.ma[15]);
  endproperty
  a_wrap15: assert property (p_wrap15)
    else $error("word mode bit 0 not from counter bit 15");

  property p_split;
    @(posedge sys_clk) disable iff (srst)
    line_adv ##1 s_r.line == $past(split11) |-> s_r.ma == 16'h0000;
  endproperty
  a_split: assert property (p_split)
    else $error("address counter not cleared at split line");

  property p_vhalve;
    @(posedge sys_clk) disable iff (srst)
    hretrace_tick && !s_r.vdiv && s_r.mode[crtc_vsplit_pkg::MD_VHALVE]
      |=> s_r.line == $past(s_r.line);
  endproperty
  a_vhalve: assert property (p_vhalve)
    else $error("line advanced on skipped retrace tick");

  property p_latch_rb;
    @(posedge sys_clk) disable iff (srst)
    reg_rd && reg_index == crtc_vsplit_pkg::IDX_CPU_LATCH
      |=> reg_rdata == $past(latch_sel);
  endproperty
  a_latch_rb: assert property (p_latch_rb)
    else $error("wrong latch plane returned");

  property p_attr_rb;
    @(posedge sys_clk) disable iff (srst)
    reg_rd && (reg_index == crtc_vsplit_pkg::IDX_ATTR_A ||
               reg_index == crtc_vsplit_pkg::IDX_ATTR_B)
      |=> reg_rdata == {~$past(attr_address_toggle), 1'b0,
                        $past(video_display_enable_flag),
                        $past(attr_index)};
  endproperty
  a_attr_rb: assert property (p_attr_rb)
    else $error("attribute readback content wrong");

  property p_ro_write;
    @(posedge sys_clk) disable iff (srst)
    reg_wr && reg_index == crtc_vsplit_pkg::IDX_CPU_LATCH
      |=> s_r.vbs == $past(s_r.vbs) && s_r.vbe == $past(s_r.vbe) &&
          s_r.mode == $past(s_r.mode) && s_r.split == $past(s_r.split);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("readback write changed a register");

  c_split: cover property (@(posedge sys_clk) disable iff (srst)
    line_adv ##1 s_r.line == split11);
  c_word: cover property (@(posedge sys_clk) disable iff (srst)
    !s_r.mode[crtc_vsplit_pkg::MD_BYTE] && char_tick && disp_active);
  c_attr_b: cover property (@(posedge sys_clk) disable iff (srst)
    reg_rd && reg_index == crtc_vsplit_pkg::IDX_ATTR_B);

endmodule : crtc_vblank_split_mode_ctl

// [sim/crt_monitor_model.sv]
// Purpose: Display monitor model watching the vertical sync and blank outputs.
// Assumes: Levels are registered in sys_clk and active high.
// Notes:   Counts rising edges only; it drives nothing back.
`timescale 1ns/10ps
module crt_monitor_model (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        vsync,
  input  wire logic        blank,
  output logic [15:0]      vsync_rises,
  output logic [15:0]      blank_rises
);
  logic vsync_r;
  logic blank_r;

  // Edges, not levels: a torn pulse would show as two frames
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vsync_r     <= 1'b0;
      blank_r     <= 1'b0;
      vsync_rises <= 16'h0000;
      blank_rises <= 16'h0000;
    end else begin
      vsync_r <= vsync;
      blank_r <= blank;
      if (vsync && !vsync_r) begin
        vsync_rises <= vsync_rises + 16'h0001;
      end
      if (blank && !blank_r) begin
        blank_rises <= blank_rises + 16'h0001;
      end
    end
  end
endmodule : crt_monitor_model

// [sim/crtc_vblank_split_mode_ctl_test.sv]
// Purpose: Self-checking bench for blank, mode control and split.
// Assumes: Outputs are sampled one edge after they are registered.
// Notes:   Row height is one line until the closing two-line rows.
`timescale 1ns/10ps
module crtc_vblank_split_mode_ctl_test;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  reg_index = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  vov = 8'h00;
  logic [7:0]  msl = 8'h00;
  logic [7:0]  xov = 8'h00;
  logic [7:0]  roff = 8'h00;
  logic [1:0]  rps = 2'h0;
  logic [10:0] vt = 11'h00a;
  logic [15:0] sa = 16'h0000;
  logic        dwm = 1'b0;
  logic        qwm = 1'b0;
  logic [31:0] latch = 32'h0;
  logic [4:0]  aidx = 5'h00;
  logic        aen = 1'b0;
  logic        atog = 1'b0;
  logic        htick = 1'b0;
  logic        ctick = 1'b0;
  logic        dact = 1'b0;
  logic        hraw = 1'b0;
  logic        vraw = 1'b0;
  logic [7:0]  reg_rdata;
  logic        hs;
  logic        vs;
  logic        vb;
  logic [15:0] maddr;
  logic [10:0] sline;
  logic [4:0]  rscan;
  logic [15:0] vs_rises;
  logic [15:0] bl_rises;
  integer      seed;
  integer      fails;
  integer      checks_done;
  logic [10:0] e_line;
  logic [10:0] st;
  logic [7:0]  en;
  logic [7:0]  d;
  logic [31:0] r;
  logic        e_vb;
  logic        ph;
  logic [7:0]  mode_s;
  logic [15:0] base;
  logic [15:0] pitch;
  logic [10:0] cf_vt [3] = '{11'h12c, 11'h028, 11'h7ff};
  logic [10:0] cf_st [3] = '{11'h105, 11'h024, 11'h601};
  logic [7:0]  cf_en [3] = '{8'h20, 8'h05, 8'h10};
  int          cf_n [3] = '{311, 50, 1570};
  logic [7:0]  md_t [8] = '{8'hc3, 8'hc0, 8'hc1, 8'hc2, 8'hc0, 8'h83,
                            8'ha3, 8'h80};
  logic [7:0]  da_t = 8'b10001111;
  logic [7:0]  rw_t [3] = '{8'h15, 8'h16, 8'h18};

  crtc_vblank_split_mode_ctl crtc_vblank_split_mode_ctl_i (
    .sys_clk(sys_clk), .srst(srst), .reg_index(reg_index),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .vertical_overflow_reg(vov),
    .max_scan_line_reg(msl), .extended_vertical_overflow_reg(xov),
    .row_offset_reg(roff), .read_plane_select_reg(rps),
    .vertical_total(vt), .start_address(sa), .dword_mode(dwm),
    .qword_mode(qwm), .cpu_latch_planes(latch), .attr_index(aidx),
    .video_display_enable_flag(aen), .attr_address_toggle(atog),
    .hretrace_tick(htick), .char_tick(ctick), .disp_active(dact),
    .hsync_raw(hraw), .vsync_raw(vraw), .hsync_out(hs),
    .vsync_out(vs), .vblank(vb), .mem_addr(maddr), .scan_line(sline),
    .row_scan(rscan));

  crt_monitor_model crt_monitor_model_i (
    .sys_clk(sys_clk), .srst(srst), .vsync(vs), .blank(vb),
    .vsync_rises(vs_rises), .blank_rises(bl_rises));

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input string what, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic do_reset;
    @(posedge sys_clk);
    srst <= 1'b1;
    vov  <= 8'h00;
    msl  <= 8'h00;
    xov  <= 8'h00;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    {e_line, st, en, e_vb, ph, mode_s} = '0;
  endtask : do_reset

  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    @(posedge sys_clk);
    reg_index <= i;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    if (i == 8'h17) mode_s = v;
  endtask : wr

  task automatic rd_chk(input logic [7:0] i, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_index <= i;
    reg_rd    <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk("reg_rdata", 16'(reg_rdata), 16'(exp));
  endtask : rd_chk

  // Waits two edges: one for the register, one to sample it settled
  task automatic settle;
    repeat (2) @(posedge sys_clk);
  endtask : settle

  task automatic line_tick;
    @(posedge sys_clk);
    htick <= 1'b1;
    @(posedge sys_clk);
    htick <= 1'b0;
    ph = ~ph;
    if (!mode_s[2] || !ph) begin
      e_line = (e_line == vt) ? 11'h000 : e_line + 11'h001;
    end
    if (e_line == st + 11'h001) e_vb = 1'b1;
    else if (e_line[7:0] == en) e_vb = 1'b0;
    settle();
    chk("scan_line", 16'(sline), 16'(e_line));
    chk("vblank", 16'(vb), 16'(e_vb));
  endtask : line_tick

  task automatic char_ticks(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      ctick <= 1'b1;
      @(posedge sys_clk);
      ctick <= 1'b0;
    end
    settle();
  endtask : char_ticks

  task automatic addr_step(input logic clr);
    line_tick();
    base = clr ? 16'h0000 : base + pitch;
    chk("mem_addr", maddr, base);
  endtask : addr_step

  function automatic logic [15:0] map_addr(input logic [15:0] c,
                                           input logic [7:0]  m,
                                           input logic        da);
    map_addr = c;
    if (!m[6]) begin
      map_addr = {c[14:0], m[5] ? c[15] : c[13]};
    end
    // Bank bits take the row scan bits, which are zero here
    if (da && !m[0]) map_addr[13] = 1'b0;
    if (da && !m[1]) map_addr[14] = 1'b0;
  endfunction : map_addr

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    seed = 32'h4e37;
    fails = 0;
    checks_done = 0;
    do_reset();
    hraw <= 1'b1;
    vraw <= 1'b1;
    settle();
    chk("sync", 16'({hs, vs}), 16'h0000);
    wr(8'h17, 8'h80);
    settle();
    chk("sync", 16'({hs, vs}), 16'h0003);
    hraw <= 1'b0;
    vraw <= 1'b0;
    settle();
    chk("sync", 16'({hs, vs}), 16'h0000);
    chk("vsync_rises", vs_rises, 16'h0001);
    do_reset();
    rd_chk(8'h17, 8'h00);
    wr(8'h17, 8'hff);
    rd_chk(8'h17, 8'hef);
    foreach (rw_t[k]) begin
      d = 8'($random(seed));
      wr(rw_t[k], d);
      rd_chk(rw_t[k], d);
    end
    for (int k = 0; k < 3; k++) wr(8'h22 + 8'(k * 2), 8'h5a);
    rd_chk(8'h17, 8'hef);
    rd_chk(8'h30, 8'h00);
    r = $random(seed);
    latch <= r;
    for (int p = 0; p < 4; p++) begin
      rps <= 2'(p);
      rd_chk(8'h22, r[8*p+:8]);
    end
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      {atog, aen, aidx} <= {d[7], d[5], d[4:0]};
      rd_chk(k[0] ? 8'h26 : 8'h24, {~d[7], 1'b0, d[5:0]});
    end
    for (int k = 0; k < 3; k++) begin
      do_reset();
      vt  <= cf_vt[k];
      vov <= {4'h0, cf_st[k][8], 3'h0};
      msl <= {2'h0, cf_st[k][9], 5'h00};
      xov <= {5'h00, cf_st[k][10], 2'h0};
      st = cf_st[k];
      en = cf_en[k];
      wr(8'h15, cf_st[k][7:0]);
      wr(8'h16, cf_en[k]);
      repeat (cf_n[k]) line_tick();
      chk("blank_rises", bl_rises, 16'h0001);
    end
    do_reset();
    vt <= 11'h00a;
    wr(8'h17, 8'h04);
    repeat (4) line_tick();
    do_reset();
    sa   <= (16'($random(seed)) & 16'h1fe0) | 16'he000;
    roff <= 8'($random(seed));
    wr(8'h18, 8'h7f);
    wr(8'h17, 8'hcb);
    repeat (11) line_tick();
    chk("mem_addr", maddr, sa);
    dact <= 1'b1;
    char_ticks(6);
    chk("mem_addr", maddr, sa + 16'h0003);
    wr(8'h17, 8'hc3);
    char_ticks(5);
    chk("mem_addr", maddr, sa + 16'h0008);
    for (int k = 0; k < 8; k++) begin
      dact <= da_t[k];
      wr(8'h17, md_t[k]);
      settle();
      chk("mem_addr", maddr,
          map_addr(sa + 16'h0008, md_t[k], da_t[k]));
    end
    dact <= 1'b0;
    wr(8'h17, 8'hc3);
    base = sa;
    for (int k = 0; k < 4; k++) begin
      {qwm, dwm} <= 2'(k);
      pitch = {8'h00, roff} << (k[1] ? 3 : k[0] ? 2 : 1);
      addr_step(1'b0);
    end
    // Bit 8 set moves the split past line 6
    vov <= 8'h10;
    wr(8'h18, 8'h06);
    addr_step(1'b0);
    addr_step(1'b0);
    vov <= 8'h00;
    wr(8'h18, 8'h07);
    addr_step(1'b1);
    addr_step(1'b0);
    // Two-line rows: the base moves only when the row wraps
    msl <= 8'h01;
    line_tick();
    chk("row_scan", 16'(rscan), 16'h0001);
    chk("mem_addr", maddr, base);
    line_tick();
    chk("row_scan", 16'(rscan), 16'h0000);
    chk("mem_addr", maddr, 16'(base + pitch));
    wrap_up();
  end
endmodule : crtc_vblank_split_mode_ctl_test
